//--- core/mbi_defs.vh
// Constants of the multiplexed bus memory interface.
`ifndef MBI_DEFS_VH
`define MBI_DEFS_VH
`define MBI_ADDR_W        16
`define MBI_DATA_W        16
`define MBI_CLK_PERIOD_NS 25
`define MBI_MAX_WAIT_NS   1000
`define MBI_MAX_WAIT_CYC  ((`MBI_MAX_WAIT_NS) / (`MBI_CLK_PERIOD_NS))
`define MBI_STATE_DIV     3
`define MBI_IDLE_BUS      16'hFFFF
`endif

//--- core/mbi_bus_master.v
// Bus master end of a multiplexed 16-bit address/data memory bus.
//
// How it works
// - One shared 16-bit bus carries address first, then data; strobe marks address.
// - While ready is low during an access, wait states are inserted, up to the wait limit.
// - Fetch marker is high during the address of an instruction fetch.
// - Fetch marker is low during the address of any other access.
// - Odd byte address drives upper byte select low; even address enables low lane.
// - Reads still signal the wanted byte; the unwanted byte is discarded.

// One access walks idle, address, hold, strobe, optional waits and done, one state
// time each. The state time is a fixed number of system clocks marked by a tick.
// The far side latches the address while the strobe is high and decodes it during
// the hold state, so a slow target has pulled ready low before it is first sampled.
// Ready is sampled only on ticks; a level that changes between ticks is not seen.
// A wait that outlasts the limit ends the access with the timeout flag set, and
// the read data of such an access must not be trusted.

`include "mbi_defs.vh"

module mbi_bus_master #(
	parameter MAX_WAIT_CYC = `MBI_MAX_WAIT_CYC
) (
	input  wire        sys_clk,
	input  wire        reset,
	input  wire        req_valid,
	input  wire        req_write,
	input  wire        req_fetch,
	input  wire        req_word,
	input  wire [15:0] req_addr,
	input  wire [15:0] req_wdata,
	output reg         req_ready,
	output reg         rsp_valid,
	output reg  [15:0] rsp_rdata,
	output reg         rsp_timeout,
	output reg         state_clock_out,
	output reg         addr_strobe,
	output reg         rd_n,
	output reg         wr_n,
	output reg         fetch_marker,
	output reg         upper_byte_sel_n,
	output reg  [15:0] ad_out,
	output reg         ad_oe_n,
	input  wire [15:0] ad_in,
	input  wire        ready
);

	localparam [5:0] ST_IDLE = 6'h01;
	localparam [5:0] ST_ADDR = 6'h02;
	localparam [5:0] ST_HOLD = 6'h04;
	localparam [5:0] ST_STRB = 6'h08;
	localparam [5:0] ST_WAIT = 6'h10;
	localparam [5:0] ST_DONE = 6'h20;

	reg [5:0]  state_q;
	reg [1:0]  div_q;
	reg        tick_q;
	reg        wr_q;
	reg        word_q;
	reg        odd_q;
	reg [15:0] wdata_q;
	reg [31:0] wait_q;
	wire       wait_spent;
	wire       wait_over;

	// The hold-off limit protects the access from a far side that never frees ready.
	// Ending on the limit trades a wrong data word for a bus that keeps moving.
	assign wait_spent = (wait_q >= MAX_WAIT_CYC);
	assign wait_over  = ready | wait_spent;

	// Write data steering: an odd byte goes out on both lanes, so the upper lane
	// carries it whichever lane the far side decodes for the write.
	function [15:0] lane_data;
		input        word;
		input        odd;
		input [15:0] data;
		begin
			if (odd & ~word)
				lane_data = {data[7:0], data[7:0]};
			else
				lane_data = data;
		end
	endfunction

	// Read data steering: a byte read returns the selected byte in the low bits.
	function [15:0] pick_byte;
		input        word;
		input        odd;
		input [15:0] bus;
		begin
			if (word)
				pick_byte = bus;
			else if (odd)
				pick_byte = {8'h00, bus[15:8]};
			else
				pick_byte = {8'h00, bus[7:0]};
		end
	endfunction

	// One state time is several system clocks; tick marks its last clock.
	always @(posedge sys_clk) begin
		if (reset) begin
			div_q           <= 2'h0;
			tick_q          <= 1'b0;
			state_clock_out <= 1'b0;
		end else begin
			tick_q <= (div_q == 2'h0);
			if (div_q == `MBI_STATE_DIV - 1)
				div_q <= 2'h0;
			else
				div_q <= div_q + 2'h1;
			// State clock out is high for the last system clock of each state time.
			state_clock_out <= (div_q == 2'h0);
		end
	end

	always @(posedge sys_clk) begin
		if (reset) begin
			state_q          <= ST_IDLE;
			req_ready        <= 1'b0;
			rsp_valid        <= 1'b0;
			rsp_rdata        <= 16'h0000;
			rsp_timeout      <= 1'b0;
			addr_strobe      <= 1'b0;
			rd_n             <= 1'b1;
			wr_n             <= 1'b1;
			fetch_marker     <= 1'b0;
			upper_byte_sel_n <= 1'b1;
			// The bus idles released and high, as a pulled-up bus would read.
			ad_out           <= `MBI_IDLE_BUS;
			ad_oe_n          <= 1'b1;
			wr_q             <= 1'b0;
			word_q           <= 1'b0;
			odd_q            <= 1'b0;
			wdata_q          <= 16'h0000;
			wait_q           <= 32'h0;
		end else begin
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			if (tick_q) begin
				case (state_q)
					ST_IDLE: begin
						// A request waits for the next tick; the ready pulse says it was taken.
						if (req_valid) begin
							req_ready        <= 1'b1;
							wr_q             <= req_write;
							word_q           <= req_word;
							odd_q            <= req_addr[0];
							wdata_q          <= req_wdata;
							ad_out           <= req_addr;
							ad_oe_n          <= 1'b0;
							addr_strobe      <= 1'b1;
							fetch_marker     <= req_fetch;
							// A word or an odd byte needs the upper lane.
							upper_byte_sel_n <= ~(req_word | req_addr[0]);
							state_q          <= ST_ADDR;
						end
					end
					ST_ADDR: begin
						addr_strobe <= 1'b0;
						state_q     <= ST_HOLD;
					end
					ST_HOLD: begin
						// Address phase is over; marker and select are no longer valid.
						fetch_marker     <= 1'b0;
						upper_byte_sel_n <= 1'b1;
						wait_q           <= 32'h0;
						if (wr_q) begin
							ad_out <= lane_data(word_q, odd_q, wdata_q);
							wr_n   <= 1'b0;
						end else begin
							ad_oe_n <= 1'b1;
							rd_n    <= 1'b0;
						end
						state_q <= ST_STRB;
					end
					ST_STRB, ST_WAIT: begin
						// Ready is sampled each state; low stretches the strobe.
						if (wait_over) begin
							rsp_timeout <= ~ready;
							if (!wr_q)
								rsp_rdata <= pick_byte(word_q, odd_q, ad_in);
							rd_n    <= 1'b1;
							wr_n    <= 1'b1;
							state_q <= ST_DONE;
						end else begin
							wait_q  <= wait_q + 32'h1;
							state_q <= ST_WAIT;
						end
					end
					ST_DONE: begin
						// The bus is freed a state after the strobe rose, once the far side let go.
						ad_oe_n   <= 1'b1;
						ad_out    <= `MBI_IDLE_BUS;
						rsp_valid <= 1'b1;
						state_q   <= ST_IDLE;
					end
					default: state_q <= ST_IDLE;
				endcase
			end
		end
	end

endmodule

//--- sim/mbi_checker.sv
// Pin relations of the bus master.
module mbi_checker #(parameter MAX_WAIT_CYC = 4) (input logic sys_clk, reset, req_fetch,
	req_word, req_ready, rsp_valid, addr_strobe, rd_n, wr_n, fetch_marker, upper_byte_sel_n,
	ad_oe_n, ready, state_clock_out, input logic [15:0] req_addr, ad_out);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge sys_clk); endclocking
	default disable iff (reset);
	a_addr_out: assert property (req_ready |-> addr_strobe && ad_out == req_addr)
		else $error("address lost");
	a_strobe_len: assert property ($rose(addr_strobe) |->
		addr_strobe[*3] ##1 !addr_strobe) else $error("strobe width");
	a_read_free: assert property (!rd_n |-> ad_oe_n) else $error("bus held in read");
	a_write_drive: assert property (!wr_n |-> !ad_oe_n) else $error("bus idle in write");
	a_wait_ready: assert property ($rose(rd_n) || $rose(wr_n) |-> $past(ready))
		else $error("strobe ended early");
	a_fetch_mark: assert property (req_ready |-> fetch_marker == req_fetch)
		else $error("fetch marker");
	a_byte_sel: assert property (req_ready |->
		upper_byte_sel_n == !(req_word || req_addr[0])) else $error("byte select");
	a_answer_time: assert property (req_ready |->
		(!rsp_valid)[*8] ##[3:60] rsp_valid) else $error("answer time");
	a_state_clock: assert property (state_clock_out |=>
		!state_clock_out ##1 !state_clock_out ##1 state_clock_out) else $error("state clock");
endmodule
bind mbi_bus_master mbi_checker #(.MAX_WAIT_CYC(MAX_WAIT_CYC)) u_chk (.sys_clk(sys_clk),
	.reset(reset), .req_fetch(req_fetch), .req_word(req_word), .req_ready(req_ready),
	.rsp_valid(rsp_valid), .addr_strobe(addr_strobe), .rd_n(rd_n), .wr_n(wr_n),
	.fetch_marker(fetch_marker), .upper_byte_sel_n(upper_byte_sel_n), .ad_oe_n(ad_oe_n),
	.ready(ready), .state_clock_out(state_clock_out), .req_addr(req_addr), .ad_out(ad_out));

//--- sim/mbi_mem_model.sv
// Far-side memory: address latch, lane write decode and read buffer.
module mbi_mem_model (input logic sys_clk, reset, addr_strobe, rd_n, wr_n, upper_byte_sel_n,
	input logic [15:0] bus, ext_low, output logic [15:0] drive, output logic ready);
	timeunit 1ns;
	timeprecision 1ps;
	logic [15:0] mem [0:32767];
	logic [15:0] la = 16'h0000;
	logic        ub_n;
	logic [3:0]  w;
	logic [15:0] port_q;
	// The two rebuilt ports sit at the word holding byte addresses 1FFE and 1FFF.
	wire         port_hit = (la[15:1] == 15'h0FFF);
	// Open-drain pins: a latched one floats high unless something outside pulls low.
	wire  [15:0] pins = port_q & ~ext_low;
	initial drive = 16'h0000;
	always @(posedge sys_clk) begin
		if (addr_strobe) begin
			la <= bus;
			ub_n <= upper_byte_sel_n;
		end
		w <= addr_strobe ? 4'h0 : w + {3'h0, w != 4'hF};
		// The upper half is slow, but it frees ready well before the longest hold-off.
		ready <= !(la[15] && w < 4'h9);
		if (!wr_n && !la[0]) mem[la[15:1]][7:0] <= bus[7:0];
		if (!wr_n && !ub_n) mem[la[15:1]][15:8] <= bus[15:8];
		if (reset) port_q <= 16'hFFFF;
		else begin
			if (!wr_n && port_hit && !la[0]) port_q[7:0] <= bus[7:0];
			if (!wr_n && port_hit && !ub_n) port_q[15:8] <= bus[15:8];
		end
		drive <= rd_n ? ~drive : port_hit ? pins : mem[la[15:1]];
	end
endmodule

//--- sim/test_muxed_bus_memory_interface.sv
// Random bench of the bus master with a far-side memory.
`define CHK(n, e, s) begin tests_run++; if ((s) !== (e)) begin mismatches++; \
	$display("[FAIL] %s expected %h seen %h", n, e, s); end end
module test_muxed_bus_memory_interface;
	timeunit 1ns;
	timeprecision 1ps;
	logic sys_clk = 1'h0, reset = 1'h1, req_valid = 1'h0, req_write = 1'h0, req_fetch = 1'h0;
	logic req_word = 1'h0, req_ready, rsp_valid, rsp_timeout, state_clock_out, addr_strobe;
	logic rd_n, wr_n, fetch_marker, upper_byte_sel_n, ad_oe_n, ready;
	logic [15:0] req_addr = 16'h0000, req_wdata = 16'h0000, rsp_rdata, ad_out, ad_in, drive, a, d, b;
	logic [15:0] ext_low = 16'h0000;
	integer mismatches = 0, tests_run = 0, seed = 32'h2A2B, n;
	always #12.5 sys_clk = ~sys_clk;
	assign ad_in = ad_oe_n ? drive : ad_out;
	mbi_bus_master #(.MAX_WAIT_CYC(4)) u_dut (.*);
	mbi_mem_model u_mem (.bus(ad_in), .*);
	function automatic logic [15:0] pick(logic x, logic [15:0] p, v);
		return x ? v : {8'h00, p[0] ? v[15:8] : v[7:0]};
	endfunction
	task automatic complete_run;
		if (mismatches == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	task automatic acc(logic w, f, x, logic [15:0] p, v);
		{req_valid, req_write, req_fetch, req_word} <= {1'h1, w, f, x};
		{req_addr, req_wdata} <= {p, v};
		for (n = 0; n < 99 && req_ready !== 1'h1; n++) @(posedge sys_clk);
		req_valid <= 1'h0;
		for (; n < 199 && rsp_valid !== 1'h1; n++) @(posedge sys_clk);
		`CHK("done", 1'h1, rsp_valid)
		`CHK("timeout", 1'h0, rsp_timeout)
		if (n > 198) complete_run;
	endtask
	initial begin
		ext_low <= 16'($random(seed));
		repeat (4) @(posedge sys_clk);
		reset <= 1'h0;
		@(posedge sys_clk);
		acc(1'h0, 1'h0, 1'h1, 16'h1FFE, 16'h0000);
		`CHK("port reset", ~ext_low, rsp_rdata)
		d = 16'($random(seed));
		acc(1'h1, 1'h0, 1'h0, 16'h1FFE, d);
		acc(1'h0, 1'h0, 1'h0, 16'h1FFF, 16'h0000);
		`CHK("port high", {8'h00, ~ext_low[15:8]}, rsp_rdata)
		acc(1'h0, 1'h0, 1'h0, 16'h1FFE, 16'h0000);
		`CHK("port low", {8'h00, d[7:0] & ~ext_low[7:0]}, rsp_rdata)
		for (int i = 0; i < 24; i++) begin
			a = i ? 16'($random(seed)) & 16'hFFFE : 16'hFFFE;
			if (a[15:1] == 15'h0FFF) a = 16'h2FFE;
			d = 16'($random(seed));
			b = 16'($random(seed));
			acc(1'h1, i[0], 1'h1, a, d);
			for (int k = 0; k < 3; k++) begin
				acc(1'h0, k[0], k == 2, a | k[0], 16'h0000);
				`CHK("read", pick(k == 2, a | k[0], d), rsp_rdata)
			end
			acc(1'h1, 1'h0, 1'h0, a | 16'h0001, b);
			acc(1'h1, 1'h1, 1'h0, a, {8'h00, b[15:8]});
			acc(1'h0, 1'h1, 1'h1, a, 16'h0000);
			`CHK("lanes", {b[7:0], b[15:8]}, rsp_rdata)
		end
		complete_run;
	end
endmodule
